// ==== drpm_map.vh ====
`ifndef DRPM_MAP_VH
`define DRPM_MAP_VH

// ==========================================================
// Register offsets (byte addresses)
// ==========================================================
`define DRPM_ADR_PDCFG     8'h00
`define DRPM_ADR_CTRL      8'h04
`define DRPM_ADR_STAT      8'h08

// ==========================================================
// Power-down configuration fields
// ==========================================================
`define DRPM_MODE_HI       15
`define DRPM_MODE_LO       12
`define DRPM_TMO_HI        11
`define DRPM_TMO_LO        0
`define DRPM_PDCFG_RST     16'h0000
`define DRPM_MODE_NONE     4'h0
`define DRPM_MODE_OPEN     4'h1
`define DRPM_MODE_PRE      4'h2
`define DRPM_MODE_DLLOFF   4'h6

// ==========================================================
// Control register fields
// ==========================================================
`define DRPM_CTL_RELEASE   0
`define DRPM_CTL_LOCK      1
`define DRPM_CTL_UNPOP_HI  7
`define DRPM_CTL_UNPOP_LO  4
`define DRPM_CTL_EXTGFX    8

// ==========================================================
// Timing
// ==========================================================
`define DRPM_CLK_MHZ       125
`define DRPM_CKE_LOW_US    200
`define DRPM_TXP_CYC       5'd5
`define DRPM_TXPDLL_CYC    5'd20

`endif

// ==== drpm_top.v ====
// Behaviour
// - Unpopulated ranks leave clock, CKE, ODT and chip-select undriven.
// - After reset all ranks count as populated; software may tri-state empty ones.
// - Four independent CKE outputs, one per rank.
// - Config register: mode in bits 15:12, idle timeout in bits 11:0.
// - Four power-down behaviours selectable in the running package state.
// - No-power-down mode never drops CKE for idle ranks.
// - Open-page power-down keeps pages, DLL on, exit waits tXP only.
// - DLL-off power-down waits tXP plus tXPDLL before first data transfer.
// - Precharged power-down needs all banks closed; wake marks pages empty.
// - Separate idle counter per rank; expiry with nothing queued allows power-down.
// - Idle counter restarts at the latest transaction to the rank.
// - Timeout counts memory clock cycles of continuous idleness.
// - Config register writable live unless registers are locked.
// - CKE stays low through reset until software writes the release bit.
// - Suspend or conditional self-refresh drains, then non-graphics ranks self-refresh.
// - Deep package with integrated graphics: self-refresh only when graphics idle.
// - Deep package with external graphics: self-refresh when nothing outstanding.
// - Running states use idle power-down; S3 self-refresh; S4 memory off.
// - Precharged modes close every open page before CKE drops.
// - Wake all ranks before refresh, power them down again after it.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`include "drpm_map.vh"
`default_nettype none

module drpm_top
#(
   parameter CKE_HOLD_CYC = `DRPM_CKE_LOW_US * `DRPM_CLK_MHZ
)
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire        ack_o,
   input  wire [3:0]  rank_txn_i,
   input  wire [3:0]  rank_queued_i,
   input  wire [3:0]  rank_open_pages_i,
   input  wire [3:0]  gfx_rank_i,
   input  wire        pkg_deep_i,
   input  wire        pkg_s3_i,
   input  wire        pkg_s4_i,
   input  wire        gfx_idle_i,
   input  wire        display_pending_i,
   input  wire        req_outstanding_i,
   input  wire        refresh_due_i,
   input  wire        refresh_done_i,
   output wire [3:0]  cke_o,
   output wire [3:0]  rank_oe_n_o,
   output wire [3:0]  self_refresh_o,
   output wire [3:0]  precharge_all_o,
   output wire [3:0]  pages_empty_o,
   output wire [3:0]  rank_ready_o,
   output wire        drain_req_o,
   output wire        refresh_ready_o,
   output wire        mem_power_off_o
);

   // =======================================================
   // State encoding and timing
   // =======================================================
   localparam [4:0] ST_ACT  = 5'h01;
   localparam [4:0] ST_CLS  = 5'h02;
   localparam [4:0] ST_PD   = 5'h04;
   localparam [4:0] ST_EXIT = 5'h08;
   localparam [4:0] ST_SR   = 5'h10;
   // The hold counter is 15 bits, enough for 200 us at 125 MHz
   localparam [14:0] HOLD_LAST = CKE_HOLD_CYC[14:0] - 15'h0001;

   // =======================================================
   // Register file
   // =======================================================
   reg  [15:0] pdcfg_reg;
   reg         release_reg;
   reg         lock_reg;
   reg  [3:0]  unpop_reg;
   reg         extgfx_reg;
   reg  [31:0] dat_reg;
   reg         ack_reg;
   reg  [14:0] hold_reg;
   reg         hold_done_reg;
   reg         ref_busy_reg;
   reg         ref_rdy_reg;
   reg         drain_reg;
   reg         off_reg;
   wire [3:0]  cke_w;
   wire [3:0]  sr_w;
   wire [3:0]  pd_w;
   wire [3:0]  awake_w;

   wire        req   = cyc_i & stb_i & ~ack_reg;
   wire        wr    = req & we_i;
   // Byte offsets (address bits 1:0) inside a word are ignored, only bits 7:2 decode
   wire        hit_p = ({adr_i[7:2], 2'b00} == `DRPM_ADR_PDCFG);
   wire        hit_c = ({adr_i[7:2], 2'b00} == `DRPM_ADR_CTRL);
   wire        hit_s = ({adr_i[7:2], 2'b00} == `DRPM_ADR_STAT);
   wire        rel   = release_reg & hold_done_reg;

   wire [3:0]  mode  = pdcfg_reg[`DRPM_MODE_HI:`DRPM_MODE_LO];
   wire [11:0] tmo   = pdcfg_reg[`DRPM_TMO_HI:`DRPM_TMO_LO];
   // Unknown mode codes behave as no power-down, the safe choice
   wire        m_open = (mode == `DRPM_MODE_OPEN);
   wire        m_pre  = (mode == `DRPM_MODE_PRE);
   wire        m_dll  = (mode == `DRPM_MODE_DLLOFF);
   wire        pd_en  = m_open | m_pre | m_dll;

   // Self-refresh wish per package state
   wire        deep_ok = extgfx_reg ? ~req_outstanding_i
                                    : (gfx_idle_i & ~display_pending_i);
   wire        sr_want = pkg_s3_i | pkg_s4_i | (pkg_deep_i & deep_ok);
   wire        sr_go   = sr_want & ~req_outstanding_i;

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pdcfg_reg   <= `DRPM_PDCFG_RST;
         release_reg <= 1'b0;
         lock_reg    <= 1'b0;
         unpop_reg   <= 4'h0;
         extgfx_reg  <= 1'b0;
         ack_reg     <= 1'b0;
         dat_reg     <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= req;
         dat_reg <= 32'h0000_0000;
         if (wr & hit_p & ~lock_reg)
         begin
            if (sel_i[0])
               pdcfg_reg[7:0] <= dat_i[7:0];
            if (sel_i[1])
               pdcfg_reg[15:8] <= dat_i[15:8];
         end
         if (wr & hit_c & ~lock_reg & sel_i[0])
         begin
            // Release and lock only ever set; reset alone clears them
            if (dat_i[`DRPM_CTL_RELEASE])
               release_reg <= 1'b1;
            if (dat_i[`DRPM_CTL_LOCK])
               lock_reg <= 1'b1;
            unpop_reg <= dat_i[`DRPM_CTL_UNPOP_HI:`DRPM_CTL_UNPOP_LO];
         end
         if (wr & hit_c & ~lock_reg & sel_i[1])
            extgfx_reg <= dat_i[`DRPM_CTL_EXTGFX];
         if (req & ~we_i)
         begin
            if (hit_p)
               dat_reg <= {16'h0000, pdcfg_reg};
            else if (hit_c)
               dat_reg <= {23'h000000, extgfx_reg, unpop_reg,
                           2'b00, lock_reg, release_reg};
            else if (hit_s)
               dat_reg <= {16'h0000, ref_rdy_reg, hold_done_reg,
                           lock_reg, release_reg, pd_w, sr_w, cke_w};
         end
      end
   end

   // =======================================================
   // Power-up hold, drain, refresh coordination
   // =======================================================
   // Hardware backs the release with its own minimum hold so a
   // premature software write cannot cut the CKE-low time short
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hold_reg      <= 15'h0000;
         hold_done_reg <= 1'b0;
         ref_busy_reg  <= 1'b0;
         ref_rdy_reg   <= 1'b0;
         drain_reg     <= 1'b0;
         off_reg       <= 1'b0;
      end
      else
      begin
         if (~hold_done_reg)
         begin
            hold_reg <= hold_reg + 15'h0001;
            if (hold_reg == HOLD_LAST)
               hold_done_reg <= 1'b1;
         end
         if (refresh_due_i)
            ref_busy_reg <= 1'b1;
         else if (refresh_done_i)
            ref_busy_reg <= 1'b0;
         ref_rdy_reg <= ref_busy_reg & ~refresh_done_i
                        & (&(awake_w | unpop_reg));
         drain_reg <= sr_want;
         off_reg   <= pkg_s4_i;
      end
   end

   // =======================================================
   // Per-rank power state machines
   // =======================================================
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_rank
         reg [4:0]  st_reg;
         reg [4:0]  st_next;
         reg [11:0] idle_reg;
         reg [11:0] idle_next;
         reg [4:0]  xcnt_reg;
         reg [4:0]  xcnt_next;
         reg        dll_reg;
         reg        dll_next;
         reg        srt_reg;
         reg        srt_next;
         reg        back_reg;
         reg        back_next;
         reg        inv_reg;
         reg        inv_next;
         reg        cke_reg;
         reg        oe_n_reg;
         reg        sref_reg;
         reg        pre_reg;
         reg        emp_reg;
         reg        rdy_reg;

         wire sr_rank = sr_go & (extgfx_reg | ~gfx_rank_i[g]);
         wire expired = (idle_reg >= tmo);
         wire wake    = rank_queued_i[g] | ref_busy_reg | refresh_due_i
                        | ~pd_en | sr_rank;

         always @*
         begin
            st_next   = st_reg;
            idle_next = idle_reg;
            xcnt_next = xcnt_reg;
            dll_next  = dll_reg;
            srt_next  = srt_reg;
            inv_next  = inv_reg;
            back_next = back_reg;
            if (refresh_done_i & pd_en)
               back_next = 1'b1;
            case (st_reg)
               ST_ACT:
               begin
                  if (rank_txn_i[g])
                     idle_next = 12'h000;
                  else if (~expired)
                     idle_next = idle_reg + 12'h001;
                  if (~rel | unpop_reg[g])
                     st_next = ST_ACT;
                  else if (sr_rank)
                  begin
                     srt_next = 1'b1;
                     st_next  = rank_open_pages_i[g] ? ST_CLS : ST_SR;
                  end
                  else if (pd_en & ~rank_queued_i[g] & ~ref_busy_reg
                           & ~refresh_due_i & (expired | back_reg))
                  begin
                     srt_next  = 1'b0;
                     back_next = 1'b0;
                     dll_next  = m_dll;
                     inv_next  = ~m_open;
                     if (m_open | ~rank_open_pages_i[g])
                        st_next = ST_PD;
                     else
                        st_next = ST_CLS;
                  end
               end
               ST_CLS:
               begin
                  if (~rank_open_pages_i[g])
                     st_next = srt_reg ? ST_SR : ST_PD;
               end
               ST_PD:
               begin
                  if (wake)
                  begin
                     st_next   = ST_EXIT;
                     xcnt_next = dll_reg ? (`DRPM_TXP_CYC + `DRPM_TXPDLL_CYC)
                                         : `DRPM_TXP_CYC;
                  end
               end
               ST_EXIT:
               begin
                  if (xcnt_reg == 5'h00)
                  begin
                     st_next   = ST_ACT;
                     idle_next = 12'h000;
                  end
                  else
                     xcnt_next = xcnt_reg - 5'h01;
               end
               ST_SR:
               begin
                  if (~sr_rank & ~pkg_s4_i)
                  begin
                     st_next   = ST_EXIT;
                     dll_next  = 1'b1;
                     inv_next  = 1'b1;
                     xcnt_next = `DRPM_TXP_CYC + `DRPM_TXPDLL_CYC;
                  end
               end
               default:
                  st_next = ST_ACT;
            endcase
         end

         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               st_reg   <= ST_ACT;
               idle_reg <= 12'h000;
               xcnt_reg <= 5'h00;
               dll_reg  <= 1'b0;
               srt_reg  <= 1'b0;
               back_reg <= 1'b0;
               inv_reg  <= 1'b0;
               cke_reg  <= 1'b0;
               oe_n_reg <= 1'b0;
               sref_reg <= 1'b0;
               pre_reg  <= 1'b0;
               emp_reg  <= 1'b0;
               rdy_reg  <= 1'b0;
            end
            else
            begin
               st_reg   <= st_next;
               idle_reg <= idle_next;
               xcnt_reg <= xcnt_next;
               dll_reg  <= dll_next;
               srt_reg  <= srt_next;
               back_reg <= back_next;
               inv_reg  <= inv_next;
               oe_n_reg <= unpop_reg[g];
               cke_reg  <= rel & ~unpop_reg[g] & ~pkg_s4_i
                           & (st_next != ST_PD) & (st_next != ST_SR);
               sref_reg <= (st_next == ST_SR);
               pre_reg  <= (st_next == ST_CLS);
               // One-cycle pulse: page buffers forgotten after wake
               emp_reg  <= (st_reg == ST_EXIT) & (st_next == ST_ACT)
                           & inv_reg;
               rdy_reg  <= rel & ~unpop_reg[g] & (st_next == ST_ACT);
            end
         end

         assign cke_o[g]           = cke_reg;
         assign rank_oe_n_o[g]     = oe_n_reg;
         assign self_refresh_o[g]  = sref_reg;
         assign precharge_all_o[g] = pre_reg;
         assign pages_empty_o[g]   = emp_reg;
         assign rank_ready_o[g]    = rdy_reg;
         assign cke_w[g]           = cke_reg;
         assign sr_w[g]            = sref_reg;
         assign pd_w[g]            = (st_reg == ST_PD);
         assign awake_w[g]         = rdy_reg;
      end
   endgenerate

   assign dat_o           = dat_reg;
   assign ack_o           = ack_reg;
   assign drain_req_o     = drain_reg;
   assign refresh_ready_o = ref_rdy_reg;
   assign mem_power_off_o = off_reg;

endmodule

`default_nettype wire

// ==== drpm_sva.sv ====
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Port checker
module drpm_sva
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire logic        pkg_s4_i,
   input wire logic [3:0]  rank_open_pages_i,
   input wire logic [3:0]  cke_o,
   input wire logic [3:0]  rank_oe_n_o,
   input wire logic [3:0]  self_refresh_o,
   input wire logic [3:0]  precharge_all_o,
   input wire logic [3:0]  pages_empty_o,
   input wire logic        refresh_ready_o,
   input wire logic        mem_power_off_o
);
   logic [3:0] closing_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Ranks told to close pages that were still open, so CKE must hold
   always @(posedge clk_i)
   begin
      closing_reg <= rst_i ? 4'h0 : (precharge_all_o & rank_open_pages_i);
   end

   a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_read_data_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_cke_low_reset: assert property ($fell(rst_i) |-> (cke_o == 4'h0) [*8])
      else $error("cke rose right after reset");
   a_unpop_cke_off: assert property ((rank_oe_n_o & cke_o) == 4'h0)
      else $error("cke high on undriven rank");
   a_sr_cke_low: assert property ((self_refresh_o & cke_o) == 4'h0)
      else $error("cke high in self-refresh");
   a_close_before_cke: assert property ((cke_o & closing_reg) == closing_reg)
      else $error("cke dropped with pages open");
   a_refresh_all_up: assert property (refresh_ready_o |-> (cke_o | rank_oe_n_o) == 4'hf)
      else $error("refresh ready with a rank down");
   a_s4_power_off: assert property ($rose(pkg_s4_i) |=> mem_power_off_o)
      else $error("memory power not cut in S4");
   a_empty_pulse: assert property ((pages_empty_o & $past(pages_empty_o)) == 4'h0)
      else $error("pages empty longer than one cycle");

   c_self_refresh: cover property (self_refresh_o != 4'h0);
   c_refresh: cover property ($rose(refresh_ready_o));
   c_wake_empty: cover property (pages_empty_o != 4'h0);
endmodule

`default_nettype wire

// ==== drpm_ranks.sv ====
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Behavioural DRAM ranks: open pages and precharge
module drpm_ranks
#(
   parameter TRP = 3
)
(
   input  wire logic       clk_i,
   input  wire logic [3:0] cke_i,
   input  wire logic [3:0] close_all_i,
   input  wire logic [3:0] open_i,
   output var  logic [3:0] open_pages_o
);
   int cnt [4];

   initial open_pages_o = 4'h0;

   always @(posedge clk_i)
   begin
      for (int r = 0; r < 4; r++)
      begin
         // An access opens a page only while the rank is clocked
         if (open_i[r] && cke_i[r])
            open_pages_o[r] <= 1'b1;
         // Pages survive open-page power-down, closing takes TRP cycles
         else if (close_all_i[r] && open_pages_o[r])
         begin
            cnt[r] <= (cnt[r] == TRP - 1) ? 0 : cnt[r] + 1;
            if (cnt[r] == TRP - 1)
               open_pages_o[r] <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ns
`include "drpm_map.vh"
`default_nettype none

module testbench;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pkg_deep_i = 0;
   logic        pkg_s3_i = 0, pkg_s4_i = 0, gfx_idle_i = 0, display_pending_i = 0;
   logic        req_outstanding_i = 0, refresh_due_i = 0, refresh_done_i = 0;
   logic        ack_o, drain_req_o, refresh_ready_o, mem_power_off_o;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h3, rank_txn_i = 4'h0, rank_queued_i = 4'h0, gfx_rank_i = 4'h0;
   logic [3:0]  open_req = 4'h0, rank_open_pages_i, cke_o, rank_oe_n_o, self_refresh_o;
   logic [3:0]  precharge_all_o, pages_empty_o, rank_ready_o;
   logic [31:0] dat_i = 32'h0, dat_o, rdat;
   int          n_fail = 0, check_count = 0;

   always #4 clk_i = ~clk_i;

   drpm_top #(.CKE_HOLD_CYC(16)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .rank_txn_i(rank_txn_i), .rank_queued_i(rank_queued_i),
      .rank_open_pages_i(rank_open_pages_i), .gfx_rank_i(gfx_rank_i),
      .pkg_deep_i(pkg_deep_i), .pkg_s3_i(pkg_s3_i), .pkg_s4_i(pkg_s4_i),
      .gfx_idle_i(gfx_idle_i), .display_pending_i(display_pending_i),
      .req_outstanding_i(req_outstanding_i), .refresh_due_i(refresh_due_i),
      .refresh_done_i(refresh_done_i), .cke_o(cke_o), .rank_oe_n_o(rank_oe_n_o),
      .self_refresh_o(self_refresh_o), .precharge_all_o(precharge_all_o),
      .pages_empty_o(pages_empty_o), .rank_ready_o(rank_ready_o),
      .drain_req_o(drain_req_o), .refresh_ready_o(refresh_ready_o),
      .mem_power_off_o(mem_power_off_o));
   drpm_ranks u_ranks (.clk_i(clk_i), .cke_i(cke_o), .close_all_i(precharge_all_o),
                       .open_i(open_req), .open_pages_o(rank_open_pages_i));

   // ==========================================
   // Shared tasks
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack_o !== 1'b1 && k < 20);
      rdat = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      chk("ack_o", 32'h1, {31'h0, ack_o});
   endtask

   task automatic txn(input int r);
      @(posedge clk_i);
      rank_txn_i[r] <= 1'b1;
      @(posedge clk_i);
      rank_txn_i[r] <= 1'b0;
   endtask

   // Queue work for a rank, count cycles from CKE rise to ready
   task automatic wake(input int r, output int n, output logic pe);
      int k;
      pe = 1'b0;
      n = 0;
      k = 0;
      @(posedge clk_i);
      rank_queued_i[r] <= 1'b1;
      while (k < 60 && cke_o[r] !== 1'b1)
      begin
         @(posedge clk_i);
         pe |= pages_empty_o[r];
         k++;
      end
      while (k < 60 && rank_ready_o[r] !== 1'b1)
      begin
         @(posedge clk_i);
         pe |= pages_empty_o[r];
         n++;
         k++;
      end
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset();
      chk("cke_o", 32'h0, cke_o);
      chk("rank_oe_n_o", 32'h0, rank_oe_n_o);
      wb(0, `DRPM_ADR_PDCFG, 32'h0);
      chk("config", 32'h0, rdat);
      wb(0, 8'h0c, 32'h0);
      chk("unmapped", 32'h0, rdat);
      wb(1, `DRPM_ADR_PDCFG, 32'h0006);
      tick(20);
      chk("cke_o", 32'h0, cke_o);
      wb(1, `DRPM_ADR_CTRL, 32'h1);
      tick(30);
      chk("cke_o", 32'hf, cke_o);
      tick(30);
      chk("cke_o", 32'hf, cke_o);
   endtask

   task automatic t_mode(input logic [15:0] cfg, input int r, input int wn, input logic pre);
      int   k, n;
      logic pe, seen;
      wb(1, `DRPM_ADR_PDCFG, {16'h0, cfg});
      wb(0, `DRPM_ADR_PDCFG, 32'h0);
      chk("config", {16'h0, cfg}, rdat);
      wake(r, n, pe);
      @(posedge clk_i);
      open_req[r] <= 1'b1;
      rank_queued_i[r] <= 1'b0;
      txn(r);
      open_req[r] <= 1'b0;
      // A second arrival before expiry must restart the count
      tick(cfg[11:0] - 3);
      txn(r);
      seen = 1'b0;
      for (k = 0; k < 300 && cke_o[r] !== 1'b0; k++)
      begin
         @(posedge clk_i);
         seen |= precharge_all_o[r];
      end
      chk("idle span", 32'h1, k > cfg[11:0]);
      chk("cke_o", 32'h0, cke_o[r]);
      chk("close all", pre, seen);
      chk("pages kept", !pre, rank_open_pages_i[r]);
      wake(r, n, pe);
      chk("exit cycles", wn, n);
      chk("pages empty", pre, pe);
      @(posedge clk_i);
      rank_queued_i[r] <= 1'b0;
   endtask

   task automatic t_refresh();
      int k;
      tick(160);
      chk("cke_o", 32'h0, cke_o);
      refresh_due_i <= 1'b1;
      for (k = 0; k < 80 && refresh_ready_o !== 1'b1; k++)
         @(posedge clk_i);
      chk("cke_o", 32'hf, cke_o);
      refresh_due_i <= 1'b0;
      refresh_done_i <= 1'b1;
      @(posedge clk_i);
      refresh_done_i <= 1'b0;
      tick(40);
      chk("cke_o", 32'h0, cke_o);
   endtask

   task automatic t_sr();
      int   k;
      logic dr;
      wb(1, `DRPM_ADR_CTRL, 32'h81);
      tick(3);
      chk("rank_oe_n_o", 32'h8, rank_oe_n_o);
      gfx_rank_i <= 4'h1;
      pkg_deep_i <= 1'b1;
      tick(40);
      chk("self_refresh_o", 32'h0, self_refresh_o);
      gfx_idle_i <= 1'b1;
      dr = 1'b0;
      for (k = 0; k < 100 && self_refresh_o === 4'h0; k++)
      begin
         @(posedge clk_i);
         dr |= drain_req_o;
      end
      chk("drain_req_o", 32'h1, dr);
      chk("self_refresh_o", 32'h6, self_refresh_o);
      pkg_s4_i <= 1'b1;
      tick(2);
      chk("mem_power_off_o", 32'h1, mem_power_off_o);
      wb(1, `DRPM_ADR_CTRL, 32'h83);
      wb(1, `DRPM_ADR_PDCFG, 32'h0);
      wb(0, `DRPM_ADR_PDCFG, 32'h0);
      chk("locked config", 32'h6080, rdat);
   endtask

   initial
   begin
      tick(12);
      rst_i <= 1'b0;
      t_reset();
      // Exit wait is tXP (plus tXPDLL) and one hand-off cycle back to active
      t_mode(16'h1006, 0, 6, 1'b0);
      t_mode(16'h2006, 2, 6, 1'b1);
      t_mode(16'h6080, 1, 26, 1'b1);
      t_refresh();
      t_sr();
      close_out();
   end

   initial
   begin
      tick(6000);
      n_fail++;
      close_out();
   end
endmodule

bind drpm_top drpm_sva u_sva (.*);

`default_nettype wire
